//--- src/usb_ctl_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 8-bit microcontroller data bus, 16-bit addresses, 200 MHz clock
// Notes:   Definitions only
`ifndef USB_CTL_PARAMS_SVH
`define USB_CTL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_USB_FUNCTION_CONTROL      16'hfffc
`define ADDR_USB_EVENT_INTERRUPT_MASK  16'hfffd

// ----------------------------------------------------------------------
// Interrupt-mask field positions
// ----------------------------------------------------------------------
`define BIT_BUS_RESET_IRQ_MASK         7
`define BIT_SUSPEND_IRQ_MASK           6
`define BIT_WAKEUP_IRQ_MASK            5
`define BIT_FRAME_IRQ_MASK             4
`define BIT_PSEUDO_FRAME_IRQ_MASK      3
`define BIT_SETUP_IRQ_MASK             2
`define BIT_SETUP_OVERWRITE_IRQ_MASK   0
`define IMASK_WRITABLE                 8'hfd

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define BIT_CONNECT                    7
`define BIT_FUNCTION_RESPOND_ENABLE    6
`define BIT_REMOTE_WAKE_REQUEST        5
`define BIT_BUS_RESET_TO_SYS_ENABLE    4
`define BIT_SHADOW_CLEAR_CONFIRM       0
`define CTRL_WRITABLE                  8'hf1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RESET_BYTE                     8'h00

// ----------------------------------------------------------------------
// Timing: remote wake request must be cleared by software in this time
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS                  5000
`define WAKE_CLEAR_LIMIT_PS            2500000
`define WAKE_CLEAR_LIMIT_CYC  (`WAKE_CLEAR_LIMIT_PS / `CLK_PERIOD_PS)

`endif

//--- src/usb_ctl_pkg.sv
// Purpose: Types shared by the USB function control register block
// Assumes: Constants live in usb_ctl_params.svh
// Notes:   Packed structs carry grouped signals
package usb_ctl_pkg;

    // ------------------------------------------------------------------
    // Event group, one bit per USB event, in mask bit order
    // ------------------------------------------------------------------
    typedef logic [7:0] usb_event_vec_t;

    // Microcontroller register access request
    typedef struct packed {
        logic        wr;        // Write strobe, one cycle
        logic        rd;        // Read strobe, one cycle
        logic [15:0] addr;      // Byte address
        logic [7:0]  wdata;     // Write data
    } mcu_req_t;

    // Wake request watch states
    typedef enum logic [1:0] {
        WAKE_IDLE,
        WAKE_ACTIVE,
        WAKE_OVERDUE
    } wake_state_t;

endpackage

//--- src/usb_bus_reset_gate.sv
// Purpose: Synchronise the USB bus reset indication and form its effects
// Assumes: Raw bus reset level arrives from the serial engine domain
// Notes:   Produces a detect pulse and the system reset request
`timescale 1ns/1ps
`default_nettype none
module usb_bus_reset_gate (
    input  wire logic i_clk,          // System clock
    input  wire logic i_rst_b,        // Synchronised reset, active low
    input  wire logic i_bus_reset,    // Raw USB bus reset level
    input  wire logic i_sys_rst_en,   // Bus reset may reset the system
    output logic      o_detect,       // One-cycle pulse on reset start
    output logic      o_level,        // Synchronised bus reset level
    output logic      o_sys_reset     // System reset request level
);
    import usb_ctl_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sync1;   // First synchroniser stage
        logic sync2;   // Second stage, safe to read
        logic prev;    // Delayed copy for edge detect
        logic det;     // Detect pulse
        logic sysr;    // System reset request
    } gate_state_t;

    gate_state_t st;       // Registered state
    gate_state_t next_st;  // Next state

    // Edge detect reads only the second stage
    always_comb begin
        next_st       = st;
        next_st.sync1 = i_bus_reset;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        next_st.det   = st.sync2 & ~st.prev;
        // Request follows the bus reset only while enabled
        next_st.sysr  = st.sync2 & i_sys_rst_en;
    end

    // Register the state
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_detect    = st.det;
    assign o_level     = st.prev;
    assign o_sys_reset = st.sysr;
endmodule
`default_nettype wire

//--- src/usb_function_control_regs.sv
// Purpose: Control and interrupt-mask registers of a USB function core
// Assumes: Microcontroller bus with one-cycle read/write strobes
// Notes:   Read data is registered, valid the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
`include "usb_ctl_params.svh"
module usb_function_control_regs #(
    parameter int WAKE_LIMIT_CYC = `WAKE_CLEAR_LIMIT_CYC // Wake hold limit
) (
    input  wire logic                       i_clk,          // 200 MHz
    input  wire logic                       i_rst_b,        // Power-on
    input  wire usb_ctl_pkg::mcu_req_t      i_req,          // MCU access
    input  wire usb_ctl_pkg::usb_event_vec_t i_event_status, // Status bits
    input  wire logic                       i_bus_reset,    // Raw level
    input  wire logic                       i_shadow_clear_wr, // Clear req
    input  wire logic                       i_shadow_set_wr,   // Set req
    output logic [7:0]                      o_rdata,        // Read data
    output logic                            o_irq,          // Interrupt
    output logic                            o_dplus_pullup_output,  // Drive
    output logic                            o_dplus_pullup_oe_b,    // OE low
    output logic                            o_function_respond_enable,
    output logic                            o_resume_drive,  // Upstream
    output logic                            o_reset_output_pin, // Pin
    output logic                            o_system_reset,  // Internal
    output logic                            o_shadow_bit,    // Mode bit
    output logic                            o_wake_overdue   // Held long
);
    import usb_ctl_pkg::*;

    // ------------------------------------------------------------------
    // Reset release synchroniser
    // ------------------------------------------------------------------
    logic rst_meta;  // First stage
    logic rst_b;     // Released reset used everywhere

    // Assert at once, release after two edges
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta <= 1'b0;
            rst_b    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrl;       // Function control register
        logic [7:0]  imask;      // Event interrupt mask register
        logic        shadow;     // Boot/normal mode shadow bit
        logic [7:0]  rdata;      // Registered read data
        logic        irq;        // Registered interrupt
        logic        pu_out;     // Pull-up drive value
        logic        pu_oe_b;    // Pull-up enable, low drives
        logic        function_respond_enable;        // Function enable copy
        logic        resume;     // Resume drive
        logic        reset_output_pin;       // Reset output pin
        logic        sysrst;     // System reset
        wake_state_t wake;       // Wake request watch
        logic [15:0] wake_cnt;   // Cycles wake request held
        logic        overdue;    // Wake request held too long
    } regs_state_t;

    regs_state_t st;       // Registered state
    regs_state_t next_st;  // Next state

    logic sel_ctrl;   // Control register addressed
    logic sel_imask;  // Mask register addressed

    assign sel_ctrl  = (i_req.addr == `ADDR_USB_FUNCTION_CONTROL);
    assign sel_imask = (i_req.addr == `ADDR_USB_EVENT_INTERRUPT_MASK);

    // ------------------------------------------------------------------
    // Bus reset detection
    // ------------------------------------------------------------------
    logic bus_rst_det;   // One-cycle detect pulse
    logic sys_rst_req;   // System reset request

    // Level output unused: the start pulse and the gated o_sys_reset level are all that is used here
    usb_bus_reset_gate u_gate (
        .i_clk        (i_clk),
        .i_rst_b      (rst_b),
        .i_bus_reset  (i_bus_reset),
        .i_sys_rst_en (st.ctrl[`BIT_BUS_RESET_TO_SYS_ENABLE]),
        .o_detect     (bus_rst_det),
        .o_level      (),
        .o_sys_reset  (sys_rst_req)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Writes keep only defined bits; reserved read zero
        if (i_req.wr && sel_ctrl) begin
            next_st.ctrl = i_req.wdata & `CTRL_WRITABLE;
        end
        if (i_req.wr && sel_imask) begin
            next_st.imask = i_req.wdata & `IMASK_WRITABLE;
        end

        // Bus reset clears function enable only connect, wake request, reset
        // enable and confirm bits are held
        if (bus_rst_det) begin
            next_st.ctrl[`BIT_FUNCTION_RESPOND_ENABLE] = 1'b0;
        end

        // Shadow clear needs confirm already set
        if (i_shadow_clear_wr &&
            st.ctrl[`BIT_SHADOW_CLEAR_CONFIRM]) begin
            next_st.shadow = 1'b0;
        end else if (i_shadow_set_wr) begin
            next_st.shadow = 1'b1;
        end

        // Read mux, unmapped reads zero
        if (i_req.rd && sel_ctrl) begin
            next_st.rdata = st.ctrl;
        end else if (i_req.rd && sel_imask) begin
            next_st.rdata = st.imask;
        end else if (i_req.rd) begin
            next_st.rdata = `RESET_BYTE;
        end

        // Each status bit gated by its mask bit
        next_st.irq = |(i_event_status & st.imask & `IMASK_WRITABLE);

        // Pull-up driven high while connected, else floating
        next_st.pu_out  = st.ctrl[`BIT_CONNECT];
        next_st.pu_oe_b = ~st.ctrl[`BIT_CONNECT];

        // Buffer manager respond gate
        next_st.function_respond_enable = st.ctrl[`BIT_FUNCTION_RESPOND_ENABLE];

        // Resume signalling follows the wake request
        next_st.resume = st.ctrl[`BIT_REMOTE_WAKE_REQUEST];

        // Enabled bus reset drives pin and system reset
        next_st.reset_output_pin   = sys_rst_req;
        next_st.sysrst = sys_rst_req;

        // Watch how long software leaves the wake request set
        case (st.wake)
            WAKE_IDLE: begin
                next_st.wake_cnt = '0;
                if (st.ctrl[`BIT_REMOTE_WAKE_REQUEST]) begin
                    next_st.wake = WAKE_ACTIVE;
                end
            end
            WAKE_ACTIVE: begin
                if (!st.ctrl[`BIT_REMOTE_WAKE_REQUEST]) begin
                    next_st.wake = WAKE_IDLE;
                end else if (int'(st.wake_cnt) >= WAKE_LIMIT_CYC - 1) begin
                    next_st.wake = WAKE_OVERDUE;
                end else begin
                    next_st.wake_cnt = st.wake_cnt + 16'h0001;
                end
            end
            WAKE_OVERDUE: begin
                if (!st.ctrl[`BIT_REMOTE_WAKE_REQUEST]) begin
                    next_st.wake = WAKE_IDLE;
                end
            end
            default: begin
                next_st.wake = WAKE_IDLE;
            end
        endcase

        // Registered flag, so the output comes straight from a flop
        next_st.overdue = (next_st.wake == WAKE_OVERDUE);
    end

    // ------------------------------------------------------------------
    // State register; all control bits zero at power-on
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_b) begin
        if (!rst_b) begin
            st         <= '0;
            st.pu_oe_b <= 1'b1;
            st.wake    <= WAKE_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata                   = st.rdata;
    assign o_irq                     = st.irq;
    assign o_dplus_pullup_output     = st.pu_out;
    assign o_dplus_pullup_oe_b       = st.pu_oe_b;
    assign o_function_respond_enable = st.function_respond_enable;
    assign o_resume_drive            = st.resume;
    assign o_reset_output_pin        = st.reset_output_pin;
    assign o_system_reset            = st.sysrst;
    assign o_shadow_bit              = st.shadow;
    assign o_wake_overdue            = st.overdue;
endmodule
`default_nettype wire

//--- verification/usb_ctl_monitor.sv
// Purpose: Port-level checks of the USB control register block
// Assumes: One clock domain, power-on reset active low
// Notes:   Bound to the design top after the module
`timescale 1ns/1ps
`default_nettype none
`include "usb_ctl_params.svh"
module usb_ctl_monitor #(
    parameter int WAKE_LIMIT_CYC = 16 // Wake hold limit in cycles
) (
    input wire logic                 i_clk,
    input wire logic                 i_rst_b,
    input wire usb_ctl_pkg::mcu_req_t i_req,
    input wire logic [7:0]           i_event_status,
    input wire logic                 i_bus_reset,
    input wire logic                 i_shadow_clear_wr,
    input wire logic                 i_shadow_set_wr,
    input wire logic [7:0]           o_rdata,
    input wire logic                 o_irq,
    input wire logic                 o_dplus_pullup_output,
    input wire logic                 o_dplus_pullup_oe_b,
    input wire logic                 o_function_respond_enable,
    input wire logic                 o_resume_drive,
    input wire logic                 o_reset_output_pin,
    input wire logic                 o_system_reset,
    input wire logic                 o_shadow_bit,
    input wire logic                 o_wake_overdue
);
    import usb_ctl_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [7:0]  rd_allow; // Bits a read may show at this address
    logic [2:0]  ctrl_hi;  // Written connect, enable and wake bits
    logic        sh_req;   // Any shadow request
    logic        st_live;  // A maskable status bit is set
    logic [15:0] held;     // Cycles the wake drive has stood
    assign ctrl_hi = i_req.wdata[7:5];
    assign sh_req  = i_shadow_clear_wr | i_shadow_set_wr;
    assign st_live = |(i_event_status & 8'hfd);
    always_comb begin
        rd_allow = 8'h00; // Unmapped reads show nothing
        if (i_req.addr == `ADDR_USB_FUNCTION_CONTROL)
            rd_allow = `CTRL_WRITABLE;
        if (i_req.addr == `ADDR_USB_EVENT_INTERRUPT_MASK)
            rd_allow = `IMASK_WRITABLE;
    end
    // Counts how long software leaves the wake request up
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            held <= 16'h0000;
        else
            held <= o_resume_drive ? held + 16'h0001 : 16'h0000;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_ctrl_wr;
        i_req.wr && i_req.addr == `ADDR_USB_FUNCTION_CONTROL;
    endsequence
    sequence s_bus_rst_start;
        $rose(i_bus_reset) && !i_req.wr;
    endsequence
    property p_oe; o_dplus_pullup_oe_b != o_dplus_pullup_output; endproperty
    property p_ctrl_out;
        s_ctrl_wr |-> ##2 {o_dplus_pullup_output, o_function_respond_enable,
                           o_resume_drive} == $past(ctrl_hi, 2);
    endproperty
    property p_conn_kept;
        !$past(i_req.wr) && !$past(i_req.wr, 2) |->
            $stable(o_dplus_pullup_output);
    endproperty
    property p_fen_clear;
        s_bus_rst_start |-> ##5 !o_function_respond_enable;
    endproperty
    property p_pin_cause;
        o_reset_output_pin |-> $past(i_bus_reset, 3) ||
            $past(i_bus_reset, 4) || $past(i_bus_reset, 5);
    endproperty
    property p_sys_eq; o_system_reset == o_reset_output_pin; endproperty
    property p_irq_cause; o_irq |-> $past(st_live); endproperty
    property p_shadow_cause;
        !$stable(o_shadow_bit) |-> $past(sh_req) || $past(sh_req, 2);
    endproperty
    property p_read_zero;
        i_req.rd |=> (o_rdata & ~$past(rd_allow)) == 8'h00;
    endproperty
    property p_wake_early;
        o_wake_overdue |-> held >= WAKE_LIMIT_CYC - 2;
    endproperty
    a_oe: assert property (p_oe) else $error("pull-up enable wrong");
    a_ctrl_out: assert property (p_ctrl_out)
        else $error("control outputs differ from write");
    a_conn_kept: assert property (p_conn_kept)
        else $error("connect changed without a write");
    a_fen_clear: assert property (p_fen_clear)
        else $error("function enable kept over bus reset");
    a_pin_cause: assert property (p_pin_cause)
        else $error("reset pin without bus reset");
    a_sys_eq: assert property (p_sys_eq)
        else $error("system reset differs from pin");
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without status");
    a_shadow_cause: assert property (p_shadow_cause)
        else $error("shadow changed without request");
    a_read_zero: assert property (p_read_zero)
        else $error("reserved bits read as one");
    a_wake_early: assert property (p_wake_early)
        else $error("wake overdue raised early");
endmodule
bind usb_function_control_regs usb_ctl_monitor #(
    .WAKE_LIMIT_CYC(WAKE_LIMIT_CYC)) u_mon (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .i_event_status(i_event_status), .i_bus_reset(i_bus_reset),
    .i_shadow_clear_wr(i_shadow_clear_wr), .i_shadow_set_wr(i_shadow_set_wr),
    .o_rdata(o_rdata), .o_irq(o_irq),
    .o_dplus_pullup_output(o_dplus_pullup_output),
    .o_dplus_pullup_oe_b(o_dplus_pullup_oe_b),
    .o_function_respond_enable(o_function_respond_enable),
    .o_resume_drive(o_resume_drive), .o_reset_output_pin(o_reset_output_pin),
    .o_system_reset(o_system_reset), .o_shadow_bit(o_shadow_bit),
    .o_wake_overdue(o_wake_overdue));
`default_nettype wire

//--- verification/usb_host_model.sv
// Purpose: Far side: host bus reset and core event levels
// Assumes: Requests arrive just after a rising edge
// Notes:   Bus reset length shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
module usb_host_model #(
    parameter int RST_CYC = 20 // Bus reset length in cycles
) (
    input  wire logic       i_clk,       // System clock
    input  wire logic       i_go,        // Start one bus reset
    input  wire logic [7:0] i_events,    // Event levels wanted
    output logic            o_bus_reset, // Bus reset level
    output logic [7:0]      o_events     // Event status to the core
);
    int cnt = 0; // Bus reset cycles left
    // Bus reset is a level held for a fixed span, as a host does
    always @(posedge i_clk) begin
        if (i_go)
            cnt <= RST_CYC;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign o_bus_reset = (cnt > 0);
    assign o_events    = i_events;
endmodule
`default_nettype wire

//--- verification/tb_usb_function_control_regs.sv
// Purpose: Self-checking bench for the USB control register block
// Assumes: 200 MHz clock, wake limit shortened to 16 cycles
// Notes:   Expected values queue against an output watcher
`timescale 1ns/1ps
`default_nettype none
`include "usb_ctl_params.svh"
module tb_usb_function_control_regs;
    import usb_ctl_pkg::*;
    typedef struct packed { logic [1:0] sel; logic [7:0] val; } note_t;
    localparam logic [15:0] CTRL = `ADDR_USB_FUNCTION_CONTROL;
    localparam logic [15:0] MASK = `ADDR_USB_EVENT_INTERRUPT_MASK;
    logic       clk = 1'b0;   // System clock
    logic       rst_b = 1'b0; // Power-on reset
    mcu_req_t   req = '0;     // Microcontroller request
    logic [7:0] ev = 8'h00;   // Event levels
    logic       go = 1'b0;    // Bus reset request
    logic       sh_clr = 1'b0;
    logic       sh_set = 1'b0;
    logic       look = 1'b0;  // Watcher samples at next edge
    logic       bus_rst, irq, pull, oe_b, function_respond_enable, wake, rpin, srst, shadow, ovd;
    logic [7:0] ev_st, rdata, got, s;
    note_t      q[$];         // Expected results, oldest first
    note_t      n;
    int         mismatches = 0;
    int         num_checks = 0;
    always #2.5 clk = ~clk;
    usb_host_model host (.i_clk(clk), .i_go(go), .i_events(ev),
        .o_bus_reset(bus_rst), .o_events(ev_st));
    usb_function_control_regs #(.WAKE_LIMIT_CYC(16)) dut (
        .i_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_event_status(ev_st),
        .i_bus_reset(bus_rst), .i_shadow_clear_wr(sh_clr),
        .i_shadow_set_wr(sh_set), .o_rdata(rdata), .o_irq(irq),
        .o_dplus_pullup_output(pull), .o_dplus_pullup_oe_b(oe_b),
        .o_function_respond_enable(function_respond_enable), .o_resume_drive(wake),
        .o_reset_output_pin(rpin), .o_system_reset(srst),
        .o_shadow_bit(shadow), .o_wake_overdue(ovd));
    // Watcher: compares the oldest note with the selected output
    always @(posedge clk) begin
        if (look) begin
            n = q.pop_front();
            got = (n.sel == 2'd0) ? rdata : (n.sel == 2'd2) ? {7'h00, irq}
                : {pull, oe_b, function_respond_enable, wake, rpin, srst, shadow, ovd};
            num_checks++;
            if (got !== n.val) begin
                mismatches++;
                $display("Error at %0t: got %h expected %h",
                         $time, got, n.val);
            end
        end
    end
    task automatic expect_val(input logic [1:0] sl, input logic [7:0] v);
        q.push_back(note_t'({sl, v}));
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
        @(posedge clk);
    endtask
    // One strobe, held for exactly one sampling edge
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        repeat (3) @(posedge clk); // Outputs are two stages behind
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] v);
        bus(1'b0, a, 8'h00);
        expect_val(2'd0, v);
    endtask
    task automatic pulse(input logic clr);
        @(posedge clk);
        if (clr) sh_clr <= 1'b1; else sh_set <= 1'b1;
        @(posedge clk);
        sh_clr <= 1'b0;
        sh_set <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic usb_reset;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // Pin group: pull-up, its enable, enable, wake, pin, sys, shadow, late
    function automatic logic [7:0] pins(input logic p, f, w, r, sh, o);
        return {p, !p, f, w, r, r, sh, o};
    endfunction
    task automatic final_report;
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        final_report;
    end
    initial begin
        void'($urandom(32'hef21046c));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(CTRL, `RESET_BYTE);
        rd(MASK, `RESET_BYTE);
        expect_val(2'd1, pins(0, 0, 0, 0, 0, 0));
        wr(MASK, 8'hff);
        rd(MASK, 8'hfd);
        wr(16'h1234, 8'hff);
        rd(16'h1234, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(MASK, 8'h01 << i);
            s = 8'($urandom()) | (8'h01 << i);
            ev <= s;
            repeat (2) @(posedge clk);
            expect_val(2'd2, {7'h00, i != 1});
            ev <= s & ~(8'h01 << i);
            repeat (2) @(posedge clk);
            expect_val(2'd2, 8'h00);
        end
        ev <= 8'h00;
        wr(CTRL, 8'hdf);
        rd(CTRL, 8'hd1);
        expect_val(2'd1, pins(1, 1, 0, 0, 0, 0));
        pulse(1'b0);
        wr(CTRL, 8'hd0);
        pulse(1'b1);
        expect_val(2'd1, pins(1, 1, 0, 0, 1, 0));
        wr(CTRL, 8'hd1);
        pulse(1'b1);
        expect_val(2'd1, pins(1, 1, 0, 0, 0, 0));
        pulse(1'b0);
        usb_reset();
        expect_val(2'd1, pins(1, 0, 0, 1, 1, 0));
        repeat (20) @(posedge clk);
        rd(CTRL, 8'h91);
        wr(CTRL, 8'h81);
        usb_reset();
        expect_val(2'd1, pins(1, 0, 0, 0, 1, 0));
        repeat (20) @(posedge clk);
        wr(CTRL, 8'ha1);
        expect_val(2'd1, pins(1, 0, 1, 0, 1, 0));
        repeat (30) @(posedge clk);
        expect_val(2'd1, pins(1, 0, 1, 0, 1, 1));
        wr(CTRL, 8'h81);
        expect_val(2'd1, pins(1, 0, 0, 0, 1, 0));
        final_report;
    end
endmodule
`default_nettype wire
